// ---- rtl/led_core_params.svh ----
// Register offsets, field positions, reset values and timing constants of the LED dimming core
`ifndef LED_CORE_PARAMS_SVH
`define LED_CORE_PARAMS_SVH
`define A_CTRL 8'h00
`define A_CMD 8'h04
`define A_STAT 8'h08
`define A_CFG_HI 4'h1
`define A_LIVE_HI 4'h2
`define CTL_EN 0
`define CTL_FS 1
`define CTL_RATE 2
`define CTL_SYNC 3
`define CTL_AUTO 4
`define CMD_LAUNCH 0
`define CMD_HOLD 1
`define CMD_STOP 2
`define CMD_RESUME 3
`define CTRL_RESET 5'h00
`define CC_RESET 8'h80
`define CFG_RESET 32'h0800_0080
`define FS_LO_UA 32'd25500
`define FS_HI_UA 32'd51000
`define CODE_FULL 32'd255
`define PWM_TICKS 9'd256
`define CLK_MHZ 5'd20
`define TB_MHZ 5'd6
`define HOLD_WORD 3'd6
`define T_MS_1 14'd90
`define T_MS_2 14'd180
`define T_MS_3 14'd360
`define T_MS_4 14'd540
`define T_MS_5 14'd800
`define T_MS_6 14'd1070
`define T_MS_7 14'd1520
`define T_MS_8 14'd2060
`define T_MS_9 14'd2500
`define T_MS_10 14'd3040
`define T_MS_11 14'd4020
`define T_MS_12 14'd5010
`define T_MS_13 14'd5990
`define T_MS_14 14'd7060
`define T_MS_15 14'd8050
`endif

// ---- rtl/led_core_pkg.sv ----
// Types shared by the LED dimming core
package led_core_pkg;
	typedef enum logic [1:0] {S_INIT, S_STBY, S_NORM} dev_state_e;
	typedef enum logic [2:0] {U_IDLE, U_HOLD1, U_GRP, U_HOLD2, U_DONE} unit_e;
	typedef struct packed {
		logic [7:0] acc;
		logic pad;
		logic exp;
		logic [1:0] place;
		logic [7:0] duty;
		logic [7:0] cc;
	} ch_cfg_s;
	typedef struct packed {
		unit_e u;
		logic [1:0] g;
		logic [1:0] s;
		logic [1:0] gr;
		logic [1:0] sr;
	} pos_s;
	typedef logic [7:0][31:0] pat_t;
	typedef logic [3:0][7:0] code4_t;
	typedef logic [3:0][15:0] peak4_t;
endpackage : led_core_pkg

// ---- rtl/led_dimming_animation_core.sv ----
// Four-channel LED dimming core: current codes, PWM, animation sequencer, AXI4-Lite registers
//
// Chosen here: the register offsets and the AXI4-Lite register port.
`timescale 1ns/1ps
`include "led_core_params.svh"

// Notes on behaviour
// (RULE1) One global full-scale bit, reset 0 for 25.5 mA, 1 gives 51 mA.
// (RULE2) Each channel holds an 8-bit current code resetting to 80h.
// (RULE3) Peak current equals full scale times code divided by 255.
// (RULE4) 8-bit PWM per channel, rate bit picks 24 kHz or 12 kHz.
// (RULE5) PWM timebase comes from an internal 6 MHz tick when sync is output.
// (RULE6) Sync bit makes the sync pin drive the timebase out or take it in.
// (RULE7) Each channel picks forward, middle or backward pulse placement.
// (RULE8) Forward pulse rises at period start and lasts the duty length.
// (RULE9) Middle pulse is centred on the period midpoint.
// (RULE10) Backward pulse falls exactly at period end.
// (RULE11) Per-channel curve bit selects linear or exponential duty mapping.
// (RULE12) Manual mode uses the configuration registers directly and at once.
// (RULE13) Autonomous mode runs three groups of four fades and two holds.
// (RULE14) Host launches the animation; device then runs it by itself.
// (RULE15) Live duty and current pattern unit are readable per channel.
// (RULE16) Host should hold the animation before reading live values.
// (RULE17) Groups two and three are skipped when their repeat count is zero.
// (RULE18) Autonomous mode takes current from the separate autonomous code.
// (RULE19) Each group has five levels and four durations; holds have one.
// (RULE20) 2-bit sequence repeat replays groups one to three 0, 1, 2 or forever.
// (RULE21) Each group has a 2-bit repeat: 0, 1, 2 or unlimited.
// (RULE22) All channels off gives standby; enable cleared gives initial state.
// (RULE23) Duration codes are 4 bits selecting 16 times from 0 s to about 8 s.
// (RULE24) A fade steps through 256 levels within its duration.
// (RULE25) Zero-duration fades and holds are skipped.
// (RULE26) Hold one shows level one of the next group, hold two level five of the last.
// (RULE27) Repeat codes: 00 zero, 01 one, 10 two, 11 unlimited.
// (RULE28) A period is 256 ticks; duty N is high for N ticks.
module led_dimming_animation_core #(
	parameter int unsigned TIME_UNIT_TICKS = 6000
) (
	input wire logic CLK,
	input wire logic RESET_N,
	input wire logic [7:0] S_AWADDR,
	input wire logic S_AWVALID,
	output logic S_AWREADY,
	input wire logic [31:0] S_WDATA,
	input wire logic [3:0] S_WSTRB,
	input wire logic S_WVALID,
	output logic S_WREADY,
	output logic [1:0] S_BRESP,
	output logic S_BVALID,
	input wire logic S_BREADY,
	input wire logic [7:0] S_ARADDR,
	input wire logic S_ARVALID,
	output logic S_ARREADY,
	output logic [31:0] S_RDATA,
	output logic [1:0] S_RRESP,
	output logic S_RVALID,
	input wire logic S_RREADY,
	input wire logic SYNC_IN,
	output logic SYNC_OUT,
	output logic SYNC_OE,
	output logic [3:0] PWM_OUT,
	output logic FULL_SCALE,
	output led_core_pkg::code4_t CURRENT_CODE,
	output led_core_pkg::peak4_t PEAK_UA
);
	import led_core_pkg::*;

	function automatic logic [31:0] mrg(logic [31:0] o, logic [31:0] n, logic [3:0] b);
		for (int k = 0; k < 4; k++) begin
			if (b[k]) o[k*8 +: 8] = n[k*8 +: 8];
		end
		return o;
	endfunction : mrg

	function automatic logic [1:0] grpt(pat_t p, logic [1:0] g);
		return p[{g, 1'b1}][25:24];
	endfunction : grpt

	// First group at or after 'from' with a non-zero repeat; 3 means none
	function automatic logic [1:0] nxt_g(pat_t p, logic [2:0] from);
		logic [1:0] r;
		r = 2'd3;
		for (int j = 2; j >= 0; j--) begin
			if (3'(j) >= from && grpt(p, 2'(j)) != 2'd0) r = 2'(j);
		end
		return r;
	endfunction : nxt_g

	function automatic logic [1:0] last_g(pat_t p);
		logic [1:0] r;
		r = 2'd3;
		for (int j = 0; j < 3; j++) begin
			if (grpt(p, 2'(j)) != 2'd0) r = 2'(j);
		end
		return r;
	endfunction : last_g

	function automatic logic [7:0] lvl(pat_t p, logic [1:0] g, logic [2:0] k);
		if (g == 2'd3) return 8'h00;
		if (k == 3'd4) return p[{g, 1'b1}][7:0];
		return p[{g, 1'b0}][{k[1:0], 3'b000} +: 8];
	endfunction : lvl

	function automatic logic [13:0] tms(logic [3:0] c);
		logic [15:0][13:0] tab;
		tab = {`T_MS_15, `T_MS_14, `T_MS_13, `T_MS_12, `T_MS_11, `T_MS_10, `T_MS_9, `T_MS_8,
			`T_MS_7, `T_MS_6, `T_MS_5, `T_MS_4, `T_MS_3, `T_MS_2, `T_MS_1, 14'h0000};
		return tab[c];
	endfunction : tms

	function automatic logic [3:0] dcode(pat_t p, pos_s q);
		case (q.u)
			U_HOLD1: return p[`HOLD_WORD][3:0];
			U_HOLD2: return p[`HOLD_WORD][7:4];
			U_GRP: return p[{q.g, 1'b1}][{q.s, 2'b00} + 5'd8 +: 4];
			default: return 4'h0;
		endcase
	endfunction : dcode

	// Entering the group chain, wrapping for sequence replays
	function automatic pos_s enter(pat_t p, logic [2:0] from, logic [1:0] sr);
		logic [1:0] sq;
		logic [1:0] g;
		logic [1:0] f;
		pos_s n;
		sq = p[`HOLD_WORD][9:8];
		g = nxt_g(p, from);
		f = nxt_g(p, 3'd0);
		n = '{u: U_HOLD2, g: 2'd0, s: 2'd0, gr: 2'd1, sr: sr};
		if (sq == 2'd0 || f == 2'd3) n.u = U_HOLD2; // RULE20
		else if (g != 2'd3) n = '{u: U_GRP, g: g, s: 2'd0, gr: 2'd1, sr: sr}; // RULE17
		else if (sq == 2'd3 || sr < sq) n = '{u: U_GRP, g: f, s: 2'd0, gr: 2'd1, sr: sr + 2'(sq != 2'd3)}; // RULE27
		return n;
	endfunction : enter

	function automatic pos_s nxt(pat_t p, pos_s q);
		logic [1:0] r;
		pos_s n;
		n = q;
		r = grpt(p, q.g);
		case (q.u)
			U_HOLD1: n = enter(p, 3'd0, 2'd1); // RULE13
			U_GRP: begin
				if (q.s != 2'd3) n.s = q.s + 2'd1;
				else if (r == 2'd3 || q.gr < r) begin // RULE21
					n.s = 2'd0;
					n.gr = q.gr + 2'(r != 2'd3);
				end else n = enter(p, {1'b0, q.g} + 3'd1, q.sr);
			end
			U_HOLD2: n.u = U_DONE;
			default: n = q;
		endcase
		return n;
	endfunction : nxt

	// Exponent in the top 3 bits, mantissa below: a cheap eye-friendly curve
	function automatic logic [7:0] expo(logic [7:0] v);
		logic [12:0] t;
		t = 13'({1'b1, v[4:0]}) << v[7:5];
		return (v == 8'h00) ? 8'h00 : 8'(t[12:5] - 8'd1);
	endfunction : expo

	logic rst_a_r, rst_n;
	logic [4:0] ctrl_r;
	logic [31:0] cfg_r [4];
	pat_t pat_r [4];
	logic [7:0] awa_r;
	logic [31:0] wd_r;
	logic [3:0] ws_r;
	logic hold_r;
	dev_state_e st_r, st_nxt;
	logic [4:0] acc_r;
	logic sin_r, sin_d_r, half_r;
	logic [7:0] pc_r;
	pos_s pos_r [4];
	logic [7:0] step_r [4];
	logic [19:0] tc_r [4];
	ch_cfg_s cfg [4];
	logic [7:0] dsrc [4], dcmp [4], ccur [4];
	logic [19:0] sl [4];
	logic [3:0] on, eff;
	pos_s pn [4];

	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			rst_a_r <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rst_a_r <= 1'b1;
			rst_n <= rst_a_r;
		end
	end

	// A low ready means that channel's item is held and waiting for its partner
	wire wr_go = ~S_AWREADY & ~S_WREADY & ~S_BVALID;
	wire wr_ctrl = wr_go && awa_r == `A_CTRL;
	wire wr_cmd = wr_go && awa_r == `A_CMD && ws_r[0];
	wire wr_cfg = wr_go && awa_r[7:4] == `A_CFG_HI;
	wire wr_pat = wr_go && awa_r[7];
	wire launch = wr_cmd & wd_r[`CMD_LAUNCH];
	wire stop = wr_cmd & wd_r[`CMD_STOP];
	wire hold_set = wr_cmd & wd_r[`CMD_HOLD];
	wire resume = wr_cmd & wd_r[`CMD_RESUME];
	wire en = ctrl_r[`CTL_EN];
	wire auto_m = ctrl_r[`CTL_AUTO];
	wire [1:0] rch = S_ARADDR[3:2];
	wire ar_go = S_ARVALID & S_ARREADY;
	wire rd_map = S_ARADDR == `A_CTRL || S_ARADDR == `A_CMD || S_ARADDR == `A_STAT || S_ARADDR[7]
		|| S_ARADDR[7:4] == `A_CFG_HI || S_ARADDR[7:4] == `A_LIVE_HI;
	wire wr_map = awa_r == `A_CTRL || awa_r == `A_CMD || awa_r == `A_STAT || awa_r[7]
		|| awa_r[7:4] == `A_CFG_HI || awa_r[7:4] == `A_LIVE_HI;
	wire [31:0] rd_mux = (S_ARADDR == `A_CTRL) ? {27'h0, ctrl_r}
		: (S_ARADDR == `A_STAT) ? {29'h0, hold_r, st_r}
		: (S_ARADDR[7:4] == `A_CFG_HI) ? cfg_r[rch]
		: (S_ARADDR[7:4] == `A_LIVE_HI) ? {17'h0, pos_r[rch].u, pos_r[rch].g, pos_r[rch].s, dsrc[rch]} // RULE15
		: S_ARADDR[7] ? pat_r[S_ARADDR[6:5]][S_ARADDR[4:2]] : 32'h0;

	// Timebase: 6 of every 20 clocks tick, or rising edges of the sync input
	wire int_tick = acc_r >= (`CLK_MHZ - `TB_MHZ);
	wire tick = ctrl_r[`CTL_SYNC] ? int_tick : (sin_r & ~sin_d_r); // RULE5 RULE6
	wire pwm_adv = tick & (~ctrl_r[`CTL_RATE] | half_r); // RULE4
	wire run = st_r != S_INIT;

	always_ff @(posedge CLK or negedge rst_n) begin
		if (!rst_n) begin
			acc_r <= 5'h00;
			sin_r <= 1'b0;
			sin_d_r <= 1'b0;
			half_r <= 1'b0;
			pc_r <= 8'h00;
			SYNC_OUT <= 1'b0;
			SYNC_OE <= 1'b0;
		end else begin
			acc_r <= int_tick ? acc_r + `TB_MHZ - `CLK_MHZ : acc_r + `TB_MHZ;
			sin_r <= SYNC_IN;
			sin_d_r <= sin_r;
			half_r <= half_r ^ tick;
			pc_r <= pc_r + 8'(pwm_adv); // RULE28
			SYNC_OUT <= ctrl_r[`CTL_SYNC] & int_tick; // RULE6
			SYNC_OE <= ctrl_r[`CTL_SYNC];
		end
	end

	always_ff @(posedge CLK or negedge rst_n) begin
		if (!rst_n) begin
			S_AWREADY <= 1'b1;
			S_WREADY <= 1'b1;
			S_ARREADY <= 1'b1;
			awa_r <= 8'h00;
			wd_r <= 32'h0;
			ws_r <= 4'h0;
			S_BVALID <= 1'b0;
			S_BRESP <= 2'b00;
			S_RVALID <= 1'b0;
			S_RDATA <= 32'h0;
			S_RRESP <= 2'b00;
		end else begin
			if (S_AWVALID & S_AWREADY) begin
				S_AWREADY <= 1'b0;
				awa_r <= S_AWADDR;
			end else if (wr_go) S_AWREADY <= 1'b1;
			if (S_WVALID & S_WREADY) begin
				S_WREADY <= 1'b0;
				wd_r <= S_WDATA;
				ws_r <= S_WSTRB;
			end else if (wr_go) S_WREADY <= 1'b1;
			if (wr_go) begin
				S_BVALID <= 1'b1;
				S_BRESP <= wr_map ? 2'b00 : 2'b10;
			end else if (S_BREADY) S_BVALID <= 1'b0;
			if (ar_go) begin
				S_RVALID <= 1'b1;
				S_ARREADY <= 1'b0;
				S_RDATA <= rd_mux;
				S_RRESP <= rd_map ? 2'b00 : 2'b10;
			end else if (S_RREADY) begin
				S_RVALID <= 1'b0;
				S_ARREADY <= 1'b1;
			end
		end
	end

	always_ff @(posedge CLK or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_r <= `CTRL_RESET; // RULE1
			hold_r <= 1'b0;
			for (int c = 0; c < 4; c++) begin
				cfg_r[c] <= `CFG_RESET; // RULE2
				pat_r[c] <= '0;
			end
		end else begin
			if (wr_ctrl && ws_r[0]) ctrl_r <= wd_r[4:0];
			if (wr_cfg) cfg_r[awa_r[3:2]] <= mrg(cfg_r[awa_r[3:2]], wd_r, ws_r); // RULE12
			if (wr_pat) pat_r[awa_r[6:5]][awa_r[4:2]] <= mrg(pat_r[awa_r[6:5]][awa_r[4:2]], wd_r, ws_r); // RULE19
			hold_r <= hold_set | (hold_r & ~(resume | launch | stop));
		end
	end

	for (genvar i = 0; i < 4; i++) begin : g_ch
		assign cfg[i] = ch_cfg_s'(cfg_r[i][27:0]);
		wire [31:0] slw = (32'(tms(dcode(pat_r[i], pos_r[i]))) * TIME_UNIT_TICKS) >> 8; // RULE23 RULE24
		assign sl[i] = slw[19:0];
		assign pn[i] = nxt(pat_r[i], pos_r[i]);
		wire [7:0] ls = lvl(pat_r[i], pos_r[i].g, {1'b0, pos_r[i].s});
		wire [7:0] le = lvl(pat_r[i], pos_r[i].g, {1'b0, pos_r[i].s} + 3'd1);
		wire [16:0] dl = 17'($signed({1'b0, le}) - $signed({1'b0, ls})) * $signed({1'b0, step_r[i]});
		wire [8:0] ramp = 9'({1'b0, ls}) + 9'($signed(dl) >>> 8);
		wire [7:0] da = (pos_r[i].u == U_GRP) ? ramp[7:0]
			: (pos_r[i].u == U_HOLD1) ? lvl(pat_r[i], nxt_g(pat_r[i], 3'd0), 3'd0) // RULE26
			: (pos_r[i].u == U_IDLE) ? 8'h00 : lvl(pat_r[i], last_g(pat_r[i]), 3'd4);
		assign dsrc[i] = auto_m ? da : cfg[i].duty; // RULE12
		assign dcmp[i] = cfg[i].exp ? expo(dsrc[i]) : dsrc[i]; // RULE11
		assign ccur[i] = auto_m ? cfg[i].acc : cfg[i].cc; // RULE18
		assign eff[i] = dsrc[i] != 8'h00 && ccur[i] != 8'h00;
		wire [8:0] d9 = {1'b0, dcmp[i]};
		wire [8:0] p9 = {1'b0, pc_r};
		wire [8:0] ms = (`PWM_TICKS - d9) >> 1;
		assign on[i] = (cfg[i].place == 2'd1) ? (p9 >= ms && p9 < ms + d9) // RULE9
			: (cfg[i].place == 2'd2) ? (p9 >= `PWM_TICKS - d9) // RULE10
			: (p9 < d9); // RULE7 RULE8
		wire [31:0] pk = (32'(ccur[i]) * (FULL_SCALE ? `FS_HI_UA : `FS_LO_UA)) / `CODE_FULL; // RULE3

		always_ff @(posedge CLK or negedge rst_n) begin
			if (!rst_n) begin
				pos_r[i] <= '{u: U_IDLE, g: 2'd0, s: 2'd0, gr: 2'd1, sr: 2'd1};
				step_r[i] <= 8'h00;
				tc_r[i] <= 20'h0;
				PWM_OUT[i] <= 1'b0;
				CURRENT_CODE[i] <= `CC_RESET;
				PEAK_UA[i] <= 16'h0;
			end else begin
				PWM_OUT[i] <= on[i] & (st_r == S_NORM);
				CURRENT_CODE[i] <= ccur[i];
				PEAK_UA[i] <= pk[15:0];
				if (stop || !run || !auto_m) begin
					pos_r[i].u <= U_IDLE;
				end else if (launch) begin // RULE14
					pos_r[i] <= '{u: U_HOLD1, g: 2'd0, s: 2'd0, gr: 2'd1, sr: 2'd1};
					step_r[i] <= 8'h00;
					tc_r[i] <= 20'h0;
				end else if (tick && !hold_r && pos_r[i].u inside {U_HOLD1, U_GRP, U_HOLD2}) begin
					if (sl[i] == 20'h0 || tc_r[i] >= sl[i] - 20'h1) begin
						tc_r[i] <= 20'h0;
						if (sl[i] == 20'h0 || step_r[i] == 8'hFF) begin // RULE25
							pos_r[i] <= pn[i];
							step_r[i] <= 8'h00;
						end else step_r[i] <= step_r[i] + 8'h01;
					end else tc_r[i] <= tc_r[i] + 20'h1;
				end
			end
		end
	end

	always_comb begin
		st_nxt = st_r;
		case (st_r)
			S_INIT: if (en) st_nxt = S_STBY;
			S_STBY: if (!en) st_nxt = S_INIT;
				else if (|eff) st_nxt = S_NORM;
			S_NORM: if (!en) st_nxt = S_INIT; // RULE22
				else if (!(|eff) || stop) st_nxt = S_STBY;
			default: st_nxt = S_INIT;
		endcase
	end

	always_ff @(posedge CLK or negedge rst_n) begin
		if (!rst_n) begin
			st_r <= S_INIT;
			FULL_SCALE <= 1'b0;
		end else begin
			st_r <= st_nxt;
			FULL_SCALE <= ctrl_r[`CTL_FS]; // RULE1
		end
	end

	default clocking @(posedge CLK); endclocking
	default disable iff (!rst_n);

	property p_fs;
		wr_ctrl && ws_r[0] |=> ##1 FULL_SCALE == $past(wd_r[`CTL_FS], 2);
	endproperty
	a_fs: assert property (p_fs) else $error("full scale bit not applied"); // RULE1
	property p_fwd;
		cfg[0].place == 2'd0 && dcmp[0] != 8'h00 && pc_r == 8'h00 && st_r == S_NORM |=> PWM_OUT[0];
	endproperty
	a_fwd: assert property (p_fwd) else $error("forward pulse not high at start"); // RULE8
	// High on the last count of the period, low on the first
	property p_back;
		cfg[2].place == 2'd2 && dcmp[2] != 8'h00 && st_r == S_NORM && (pc_r == 8'hFF || pc_r == 8'h00)
			|=> PWM_OUT[2] == $past(pc_r[0]);
	endproperty
	a_back: assert property (p_back) else $error("backward pulse misplaced"); // RULE10
	property p_mid;
		cfg[1].place == 2'd1 && dcmp[1] >= 8'h02 && pc_r == 8'h80 && st_r == S_NORM |=> PWM_OUT[1];
	endproperty
	a_mid: assert property (p_mid) else $error("middle pulse not on midpoint"); // RULE9
	property p_zero;
		dcmp[0] == 8'h00 |=> !PWM_OUT[0];
	endproperty
	a_zero: assert property (p_zero) else $error("zero duty produced output"); // RULE28
	property p_skip;
		pos_r[0].u == U_GRP |-> grpt(pat_r[0], pos_r[0].g) != 2'd0;
	endproperty
	a_skip: assert property (p_skip) else $error("zero-repeat group executed"); // RULE17
	sequence s_launch;
		launch && auto_m && run && !stop;
	endsequence
	property p_launch;
		s_launch |=> pos_r[0].u == U_HOLD1 && step_r[0] == 8'h00;
	endproperty
	a_launch: assert property (p_launch) else $error("launch did not start pattern"); // RULE14
	property p_init;
		!en |=> st_r == S_INIT;
	endproperty
	a_init: assert property (p_init) else $error("enable cleared but not initial"); // RULE22
	property p_acc;
		auto_m && $stable(cfg_r[0]) |=> CURRENT_CODE[0] == $past(cfg[0].acc);
	endproperty
	a_acc: assert property (p_acc) else $error("autonomous current not used"); // RULE18
endmodule : led_dimming_animation_core

// ---- testbench/axi_host_model.sv ----
// Host controller model: AXI4-Lite master that programs and polls the LED core
`timescale 1ns/1ps
`include "led_core_params.svh"
module axi_host_model (
	input wire logic clk,
	output logic [7:0] awaddr,
	output logic awvalid,
	input wire logic awready,
	output logic [31:0] wdata,
	output logic [3:0] wstrb,
	output logic wvalid,
	input wire logic wready,
	input wire logic [1:0] bresp,
	input wire logic bvalid,
	output logic bready,
	output logic [7:0] araddr,
	output logic arvalid,
	input wire logic arready,
	input wire logic [31:0] rdata,
	input wire logic [1:0] rresp,
	input wire logic rvalid,
	output logic rready
);
	initial begin
		awaddr = 8'h00;
		awvalid = 1'b0;
		wdata = 32'h0;
		wstrb = 4'hF;
		wvalid = 1'b0;
		bready = 1'b0;
		araddr = 8'h00;
		arvalid = 1'b0;
		rready = 1'b0;
	end

	// Released payloads flip so a slave that samples late sees garbage
	task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		logic aw_done;
		logic w_done;
		aw_done = 1'b0;
		w_done = 1'b0;
		@(posedge clk);
		awaddr <= a;
		awvalid <= 1'b1;
		wdata <= d;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!(aw_done && w_done)) begin
			@(posedge clk);
			if (awvalid && awready) begin
				aw_done = 1'b1;
				awvalid <= 1'b0;
				awaddr <= ~a;
			end
			if (wvalid && wready) begin
				w_done = 1'b1;
				wvalid <= 1'b0;
				wdata <= ~d;
			end
		end
		while (!bvalid) @(posedge clk);
		r = bresp;
		bready <= 1'b0;
	endtask : wr

	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do @(posedge clk); while (!(arvalid && arready));
		arvalid <= 1'b0;
		araddr <= ~a;
		do @(posedge clk); while (!rvalid);
		d = rdata;
		r = rresp;
		rready <= 1'b0;
	endtask : rd

	task automatic launch();
		logic [1:0] r;
		wr(`A_CMD, 32'h1 << `CMD_LAUNCH, r);
	endtask : launch

	// Pause first so duty and progress belong to the same instant
	task automatic snap(input logic [1:0] ch, output logic [31:0] v);
		logic [1:0] r;
		wr(`A_CMD, 32'h1 << `CMD_HOLD, r);
		rd(8'h20 + {4'h0, ch, 2'h0}, v, r);
	endtask : snap
endmodule : axi_host_model

// ---- testbench/tb.sv ----
// Self-checking bench for the four-channel LED dimming core
`timescale 1ns/1ps
`include "led_core_params.svh"
module tb;
	import led_core_pkg::*;
	logic clk;
	logic reset_n;
	logic ext_tk = 1'b0;
	logic [1:0] tdiv = 2'h0;
	logic [3:0] cur4;
	logic [31:0] rv;
	logic [1:0] rsp;
	int error_cnt;
	int n_tests;
	int d, n, h;
	logic [7:0] awaddr, araddr;
	logic [31:0] wdata, rdata;
	logic [3:0] wstrb, pwm;
	logic [1:0] bresp, rresp;
	logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
	logic sync_pin, sync_out, sync_oe, fs;
	code4_t cc;
	peak4_t peak;

	// Pin level: the core drives it when its sync bit sets sync_oe, else the external timebase does
	assign sync_pin = sync_oe ? sync_out : ext_tk;

	led_dimming_animation_core #(.TIME_UNIT_TICKS(3)) u_dut (
		.CLK(clk), .RESET_N(reset_n),
		.S_AWADDR(awaddr), .S_AWVALID(awvalid), .S_AWREADY(awready),
		.S_WDATA(wdata), .S_WSTRB(wstrb), .S_WVALID(wvalid), .S_WREADY(wready),
		.S_BRESP(bresp), .S_BVALID(bvalid), .S_BREADY(bready),
		.S_ARADDR(araddr), .S_ARVALID(arvalid), .S_ARREADY(arready),
		.S_RDATA(rdata), .S_RRESP(rresp), .S_RVALID(rvalid), .S_RREADY(rready),
		.SYNC_IN(sync_pin), .SYNC_OUT(sync_out), .SYNC_OE(sync_oe),
		.PWM_OUT(pwm), .FULL_SCALE(fs), .CURRENT_CODE(cc), .PEAK_UA(peak)
	);

	axi_host_model u_host (
		.clk(clk), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
		.wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
		.bresp(bresp), .bvalid(bvalid), .bready(bready),
		.araddr(araddr), .arvalid(arvalid), .arready(arready),
		.rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready)
	);

	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	// External timebase: one tick every four clocks
	always @(posedge clk) begin
		tdiv <= tdiv + 2'h1;
		ext_tk <= tdiv[1];
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] want);
		n_tests++;
		if (got !== want) begin
			error_cnt++;
			$display("Error at %0t: seen %h expected %h", $time, got, want);
		end
	endtask : chk

	task automatic give_verdict();
		if (error_cnt == 0 && n_tests > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : give_verdict

	// Samples every st clocks; d = samples to next rise, then n and h over one period
	task automatic meas(input int ch, input int st, output int dd, output int nn, output int hh);
		logic pv;
		dd = 0;
		nn = 0;
		hh = 0;
		do begin
			pv = cur4[ch];
			repeat (st) @(posedge clk);
			cur4 = pwm;
			dd++;
		end while (!(cur4[ch] && !pv));
		do begin
			nn++;
			hh += int'(cur4[ch]);
			pv = cur4[ch];
			repeat (st) @(posedge clk);
			cur4 = pwm;
		end while (!(cur4[ch] && !pv));
	endtask : meas

	task automatic t_reset();
		chk(fs, 1'b0);
		chk(cc, {4{8'h80}});
		u_host.rd(8'h10, rv, rsp);
		chk(rv, `CFG_RESET);
		u_host.rd(8'h0C, rv, rsp);
		chk(rsp, 2'b10);
		u_host.wr(8'h0C, 32'h0, rsp);
		chk(rsp, 2'b10);
	endtask : t_reset

	task automatic t_current();
		u_host.wr(`A_CTRL, 32'h1, rsp);
		chk(rsp, 2'b00);
		u_host.rd(`A_STAT, rv, rsp);
		chk(rv[1:0], 2'd1);
		u_host.wr(8'h10, 32'h0000_01FF, rsp);
		repeat (3) @(posedge clk);
		chk(cc[0], 8'hFF);
		chk(peak[0], 16'(`FS_LO_UA));
		u_host.wr(`A_CTRL, 32'h3, rsp);
		repeat (3) @(posedge clk);
		chk(fs, 1'b1);
		chk(peak[0], 16'(`FS_HI_UA));
		chk(peak[1], 16'(`FS_HI_UA * 32'h80 / `CODE_FULL));
		u_host.rd(`A_STAT, rv, rsp);
		chk(rv[1:0], 2'd2);
		u_host.wr(`A_CTRL, 32'h0, rsp);
		u_host.rd(`A_STAT, rv, rsp);
		chk(rv[1:0], 2'd0);
	endtask : t_current

	task automatic t_place();
		u_host.wr(`A_CTRL, 32'h1, rsp);
		u_host.wr(8'h10, 32'h0000_4080, rsp);
		u_host.wr(8'h14, 32'h0001_4080, rsp);
		u_host.wr(8'h18, 32'h0002_4080, rsp);
		chk(sync_oe, 1'b0);
		cur4 = pwm;
		meas(0, 4, d, n, h);
		chk(n, 256);
		chk(h, 64);
		meas(1, 4, d, n, h);
		chk(d, 96);
		chk(h, 64);
		meas(2, 4, d, n, h);
		chk(d, 96);
		chk(h, 64);
	endtask : t_place

	task automatic t_rate();
		u_host.wr(`A_CTRL, 32'h5, rsp);
		meas(0, 4, d, n, h);
		chk(n, 512);
		chk(h, 128);
		u_host.wr(`A_CTRL, 32'h9, rsp);
		meas(0, 1, d, n, h);
		chk(32'(n >= 853 && n <= 854), 32'h1);
		chk(sync_oe, 1'b1);
		h = 0;
		repeat (20) begin
			@(posedge clk);
			h += int'(sync_out);
		end
		chk(h, 6);
	endtask : t_rate

	task automatic t_curve();
		u_host.wr(`A_CTRL, 32'h1, rsp);
		u_host.wr(8'h10, 32'h0004_FF80, rsp);
		meas(0, 4, d, n, h);
		chk(h, 251);
		u_host.wr(8'h10, 32'h0000_FF80, rsp);
		meas(0, 4, d, n, h);
		chk(h, 255);
	endtask : t_curve

	task automatic t_auto();
		logic seen;
		logic bad;
		seen = 1'b0;
		bad = 1'b0;
		u_host.wr(8'h80, 32'h4030_2010, rsp);
		u_host.wr(8'h84, 32'h0111_1150, rsp);
		u_host.wr(8'h8C, 32'h0, rsp);
		u_host.wr(8'h94, 32'h0, rsp);
		u_host.wr(8'h98, 32'h0000_0111, rsp);
		u_host.wr(8'h10, 32'h09A0_0080, rsp);
		u_host.wr(`A_CTRL, 32'h11, rsp);
		u_host.launch();
		u_host.snap(2'd0, rv);
		chk(rv[14:12], U_HOLD1);
		chk(rv[7:0], 8'h10);
		chk(cc[0], 8'h9A);
		u_host.rd(`A_STAT, rv, rsp);
		chk(rv[2:0], 3'h6);
		do begin
			u_host.wr(`A_CMD, 32'h1 << `CMD_RESUME, rsp);
			u_host.snap(2'd0, rv);
			if (rv[14:12] === U_GRP) begin
				seen = 1'b1;
				bad = bad | (rv[11:10] !== 2'd0);
			end
			if (rv[14:12] === U_HOLD2) begin
				chk(rv[7:0], 8'h50);
			end
		end while (rv[14:12] !== U_DONE);
		chk(seen, 1'b1);
		chk(bad, 1'b0);
		u_host.wr(`A_CMD, 32'h1 << `CMD_STOP, rsp);
		u_host.rd(`A_STAT, rv, rsp);
		chk(rv[2:0], 3'h1);
		u_host.rd(8'h20, rv, rsp);
		chk(rv[14:12], U_IDLE);
	endtask : t_auto

	initial begin
		repeat (80000) @(posedge clk);
		error_cnt++;
		give_verdict();
	end

	initial begin
		reset_n = 1'b0;
		repeat (6) @(posedge clk);
		reset_n <= 1'b1;
		repeat (3) @(posedge clk);
		t_reset();
		t_current();
		t_place();
		t_rate();
		t_curve();
		t_auto();
		give_verdict();
	end
endmodule : tb
